/* File: logic/cpx_pkg.sv */
package cpx_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_INSTR      = 8'h00;
	localparam logic [7:0] REG_PC         = 8'h04;
	localparam logic [7:0] REG_PSW        = 8'h08;
	localparam logic [7:0] REG_SAVED_PC   = 8'h0C;
	localparam logic [7:0] REG_SAVED_PSW  = 8'h10;
	localparam logic [7:0] REG_CAUSE      = 8'h14;
	localparam logic [7:0] REG_GPR_SEL    = 8'h18;
	localparam logic [7:0] REG_GPR_DATA   = 8'h1C;
	localparam logic [7:0] REG_STATUS     = 8'h20;

	// ----------------------------------------------------------------
	// status word bits and reset values
	// ----------------------------------------------------------------
	localparam int PSW_NULL_BIT       = 0;
	localparam int PSW_NEG_BIT        = 1;
	localparam int PSW_WRAP_BIT       = 2;
	localparam int PSW_CARRY_BIT      = 3;
	localparam int PSW_CLAMP_BIT      = 4;
	localparam int PSW_IRQ_BLOCK_BIT  = 5;
	localparam int PSW_FAULT_BIT      = 6;
	localparam int STATUS_BUSY_BIT    = 0;
	localparam int STATUS_ILLEGAL_BIT = 1;
	localparam logic [31:0] RST_PC    = 32'h0000_0000;
	localparam logic [31:0] RST_PSW   = 32'h0000_0000;

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	localparam logic [5:0]  OP_SUBTRACT       = 6'h0D;
	localparam logic [5:0]  OP_REVERSE_DIFF   = 6'h0C;
	localparam logic [5:0]  OP_AND_FLAGS_ONLY = 6'h0B;
	localparam logic [5:0]  OP_EXCL_OR        = 6'h09;
	localparam logic [5:0]  OP_EXCL_OR_LIT    = 6'h35;
	localparam logic [5:0]  OP_EXTENDED       = 6'h3F;
	localparam logic [5:0]  OP_BIT_PROBE_DISP = 6'h3E;
	localparam logic [10:0] OPX_TABLE_JUMP    = 11'h002;
	localparam logic [10:0] OPX_ZERO_BYTE     = 11'h004;
	localparam logic [10:0] OPX_SIGN_BYTE     = 11'h005;
	localparam logic [10:0] OPX_ZERO_HALF     = 11'h006;
	localparam logic [10:0] OPX_SIGN_HALF     = 11'h007;
	localparam logic [10:0] OPX_SW_EXCEPTION  = 11'h03F;
	localparam logic [15:0] SH_SYSREG_READ    = 16'h0000;
	localparam logic [15:0] SH_BIT_PROBE_REG  = 16'h00E6;
	localparam logic [15:0] SH_SW_EXCEPTION   = 16'h0100;

	// ----------------------------------------------------------------
	// system register numbers, exception entry
	// ----------------------------------------------------------------
	localparam logic [4:0]  SR_SAVED_PC       = 5'h00;
	localparam logic [4:0]  SR_SAVED_PSW      = 5'h01;
	localparam logic [4:0]  SR_CAUSE          = 5'h04;
	localparam logic [4:0]  SR_PSW            = 5'h05;
	localparam logic [15:0] EXC_CODE_BASE     = 16'h0040;
	localparam logic [31:0] HANDLER_LOW       = 32'h0000_0040;
	localparam logic [31:0] HANDLER_HIGH      = 32'h0000_0050;
	localparam logic [31:0] STEP_SHORT        = 32'h0000_0002;
	localparam logic [31:0] STEP_LONG         = 32'h0000_0004;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_WAIT = 3'b100
	} cpx_phase_e;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} cpx_apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} cpx_apb_rsp_s;

	typedef struct packed {
		logic        req;
		logic        half;
		logic [31:0] addr;
	} cpx_mem_req_s;

	typedef struct packed {
		cpx_phase_e       phase;
		logic [31:0]      instr;
		logic [31:0]      pc;
		logic [31:0]      programStatusWord;
		logic [31:0]      savedReturnPc;
		logic [31:0]      savedStatusWord;
		logic [31:0]      exceptionCauseReg;
		logic [4:0]       gprSel;
		logic [2:0]       bitSel;
		logic             illegal;
		cpx_apb_rsp_s     apb;
		cpx_mem_req_s     mem;
		logic [31:0][31:0] gpr;
	} cpx_state_s;

endpackage

/* File: logic/cpx_exec.sv */
// What this block does
// - system register read copies into destination
// - difference writes destination minus source
// - subtracts update carry, wrap, negative, null
// - table entry address is pc+2 plus source*2
// - table jump adds loaded halfword*2, branches
// - byte sign widening, flags unchanged
// - halfword sign widening, flags unchanged
// - byte zero widening, flags unchanged
// - halfword zero widening, flags unchanged
// - exception saves pc+4 and status word
// - exception cause code is 40H plus vector
// - exception sets fault and irq block flags
// - exception branches to 40H or 50H
// - and-test updates flags only, clears wrap
// - bit probe form one: source plus offset
// - bit probe form two: index from destination
// - bit probe null flag is inverted bit
// - register xor writes destination, sets flags
// - literal xor uses zero-extended literal
//
// Decided for this implementation: the APB slave port and the register offsets.
module cpx_exec
	import cpx_pkg::*;
(
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire cpx_apb_req_s apbReq,
	output cpx_apb_rsp_s      apbRsp,
	output cpx_mem_req_s      memReq,
	input  wire logic         memAck,
	input  wire logic [15:0]  memRdData
);

	localparam cpx_state_s ST_RESET = '{
		phase: ST_IDLE, pc: RST_PC, programStatusWord: RST_PSW,
		default: '0};

	cpx_state_s  st;
	cpx_state_s  next_st;

	logic [5:0]  op;
	logic [10:0] hi11;
	logic [15:0] upper;
	logic [4:0]  rs;
	logic [4:0]  rd;
	logic [31:0] a;
	logic [31:0] b;
	logic        busy;
	logic        dSub;
	logic        dSubr;
	logic        dTst;
	logic        dXor;
	logic        dXori;
	logic        dSysrd;
	logic        dTrap;
	logic        dSwitch;
	logic        dBit1;
	logic        dBit2;
	logic        dExt;
	logic        longForm;
	logic [31:0] minu;
	logic [31:0] subt;
	logic [32:0] diff;
	logic [31:0] logicRes;
	logic [31:0] extRes;
	logic [31:0] sysrdVal;
	logic        wrEn;
	logic [4:0]  wrIdx;
	logic [31:0] wrData;
	logic        apbAcc;
	logic        apbWr;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	assign op       = st.instr[10:5];
	assign hi11     = st.instr[15:5];
	assign upper    = st.instr[31:16];
	assign rs       = st.instr[4:0];
	assign rd       = st.instr[15:11];
	assign a        = st.gpr[rs];
	assign b        = st.gpr[rd];
	assign busy     = st.phase != ST_IDLE;
	assign longForm = st.instr[10:9] == 2'b11;
	assign dSub     = op == OP_SUBTRACT;
	assign dSubr    = op == OP_REVERSE_DIFF;
	assign dTst     = op == OP_AND_FLAGS_ONLY;
	assign dXor     = op == OP_EXCL_OR;
	assign dXori    = op == OP_EXCL_OR_LIT;
	assign dTrap    = hi11 == OPX_SW_EXCEPTION && upper == SH_SW_EXCEPTION;
	assign dSysrd   = op == OP_EXTENDED && upper == SH_SYSREG_READ;
	assign dBit2    = op == OP_EXTENDED && upper == SH_BIT_PROBE_REG;
	assign dBit1    = op == OP_BIT_PROBE_DISP && st.instr[15:14] == 2'b11;
	assign dSwitch  = hi11 == OPX_TABLE_JUMP;
	assign dExt     = hi11 == OPX_ZERO_BYTE || hi11 == OPX_SIGN_BYTE ||
		hi11 == OPX_ZERO_HALF || hi11 == OPX_SIGN_HALF;

	assign apbRsp   = st.apb;
	assign memReq   = st.mem;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.apb.pready = 1'b0;
		next_st.apb.pslverr = 1'b0;
		wrEn = 1'b0;
		wrIdx = rd;
		wrData = '0;
		minu = dSubr ? a : b;
		subt = dSubr ? b : a;
		diff = {1'b0, minu} - {1'b0, subt};
		if (dTst)
			logicRes = a & b;
		else if (dXori)
			logicRes = a ^ {16'h0000, upper};
		else
			logicRes = a ^ b;
		unique case (hi11)
			OPX_SIGN_BYTE: extRes = {{24{a[7]}}, a[7:0]};
			OPX_SIGN_HALF: extRes = {{16{a[15]}}, a[15:0]};
			OPX_ZERO_BYTE: extRes = {24'h000000, a[7:0]};
			default:       extRes = {16'h0000, a[15:0]};
		endcase
		// reserved numbers have no defined value; zero is returned
		unique case (rs)
			SR_SAVED_PC:  sysrdVal = st.savedReturnPc;
			SR_SAVED_PSW: sysrdVal = st.savedStatusWord;
			SR_CAUSE:     sysrdVal = st.exceptionCauseReg;
			SR_PSW:       sysrdVal = st.programStatusWord;
			default:      sysrdVal = '0;
		endcase

		unique case (st.phase)
			ST_IDLE: begin
			end
			ST_EXEC: begin
				next_st.phase = ST_IDLE;
				next_st.pc = st.pc + (longForm ? STEP_LONG : STEP_SHORT);
				if (dSub || dSubr) begin
					wrEn = 1'b1;
					wrData = diff[31:0];
					next_st.programStatusWord[PSW_CARRY_BIT] = diff[32];
					next_st.programStatusWord[PSW_WRAP_BIT] =
						(minu[31] ^ subt[31]) & (diff[31] ^ minu[31]);
					next_st.programStatusWord[PSW_NEG_BIT] = diff[31];
					next_st.programStatusWord[PSW_NULL_BIT] =
						diff[31:0] == 32'h0000_0000;
				end else if (dTst || dXor || dXori) begin
					wrEn = !dTst;
					wrData = logicRes;
					next_st.programStatusWord[PSW_WRAP_BIT] = 1'b0;
					next_st.programStatusWord[PSW_NEG_BIT] = logicRes[31];
					next_st.programStatusWord[PSW_NULL_BIT] =
						logicRes == 32'h0000_0000;
				end else if (dExt) begin
					wrEn = 1'b1;
					wrIdx = rs;
					wrData = extRes;
				end else if (dSysrd) begin
					wrEn = 1'b1;
					wrData = sysrdVal;
				end else if (dTrap) begin
					next_st.savedReturnPc = st.pc + STEP_LONG;
					next_st.savedStatusWord = st.programStatusWord;
					next_st.exceptionCauseReg[15:0] =
						EXC_CODE_BASE + {11'h000, rs};
					next_st.programStatusWord[PSW_FAULT_BIT] = 1'b1;
					next_st.programStatusWord[PSW_IRQ_BLOCK_BIT] = 1'b1;
					next_st.pc = rs[4] ? HANDLER_HIGH : HANDLER_LOW;
				end else if (dSwitch) begin
					next_st.phase = ST_WAIT;
					next_st.pc = st.pc;
					next_st.mem.req = 1'b1;
					next_st.mem.half = 1'b1;
					next_st.mem.addr = st.pc + STEP_SHORT +
						{a[30:0], 1'b0};
				end else if (dBit1 || dBit2) begin
					next_st.phase = ST_WAIT;
					next_st.pc = st.pc;
					next_st.mem.req = 1'b1;
					next_st.mem.half = 1'b0;
					next_st.mem.addr = dBit1 ?
						a + {{16{upper[15]}}, upper} : a;
					next_st.bitSel = dBit1 ?
						st.instr[13:11] : b[2:0];
				end else begin
					next_st.illegal = 1'b1;
				end
			end
			ST_WAIT: begin
				if (memAck) begin
					next_st.phase = ST_IDLE;
					next_st.mem.req = 1'b0;
					if (dSwitch) begin
						next_st.pc = st.pc + STEP_SHORT +
							{{15{memRdData[15]}}, memRdData, 1'b0};
					end else begin
						next_st.pc = st.pc + STEP_LONG;
						next_st.programStatusWord[PSW_NULL_BIT] =
							~memRdData[st.bitSel];
					end
				end
			end
		endcase
		if (wrEn && wrIdx != 5'h00)
			next_st.gpr[wrIdx] = wrData;

		// ------------------------------------------------------------
		// apb slave: one wait state, writes land on completion edge
		// ------------------------------------------------------------
		apbAcc = apbReq.psel & apbReq.penable & ~st.apb.pready;
		apbWr = apbReq.psel & apbReq.penable & apbReq.pwrite &
			st.apb.pready & ~st.apb.pslverr;
		if (apbAcc) begin
			next_st.apb.pready = 1'b1;
			next_st.apb.pslverr = apbReq.pwrite & busy;
			next_st.apb.prdata = '0;
		end
		if (apbAcc || apbWr) begin
			case (apbReq.paddr)
				REG_INSTR: begin
					next_st.apb.prdata = st.instr;
					if (apbWr) begin
						next_st.instr = apbReq.pwdata;
						next_st.phase = ST_EXEC;
						next_st.illegal = 1'b0;
					end
				end
				REG_PC: begin
					next_st.apb.prdata = st.pc;
					if (apbWr)
						next_st.pc = apbReq.pwdata;
				end
				REG_PSW: begin
					next_st.apb.prdata = st.programStatusWord;
					if (apbWr)
						next_st.programStatusWord = apbReq.pwdata;
				end
				REG_SAVED_PC: begin
					next_st.apb.prdata = st.savedReturnPc;
					if (apbWr)
						next_st.savedReturnPc = apbReq.pwdata;
				end
				REG_SAVED_PSW: begin
					next_st.apb.prdata = st.savedStatusWord;
					if (apbWr)
						next_st.savedStatusWord = apbReq.pwdata;
				end
				REG_CAUSE: begin
					next_st.apb.prdata = st.exceptionCauseReg;
					if (apbWr)
						next_st.exceptionCauseReg = apbReq.pwdata;
				end
				REG_GPR_SEL: begin
					next_st.apb.prdata = {27'h0, st.gprSel};
					if (apbWr)
						next_st.gprSel = apbReq.pwdata[4:0];
				end
				REG_GPR_DATA: begin
					next_st.apb.prdata = st.gpr[st.gprSel];
					if (apbWr && st.gprSel != 5'h00)
						next_st.gpr[st.gprSel] = apbReq.pwdata;
				end
				REG_STATUS: begin
					next_st.apb.prdata[STATUS_BUSY_BIT] = busy;
					next_st.apb.prdata[STATUS_ILLEGAL_BIT] = st.illegal;
				end
				default: next_st.apb.pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			st <= ST_RESET;
		else
			st <= next_st;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	logic execNow;
	logic psWr;
	assign execNow = st.phase == ST_EXEC;
	assign psWr = apbWr && apbReq.paddr == REG_PSW;

	sub_result_a: assert property (
		execNow && dSub && rd != 5'h00 |=>
		st.gpr[$past(rd)] == $past(b) - $past(a))
		else $error("difference result wrong");

	reverse_difference_instr_carry_a: assert property (
		execNow && dSubr |=> st.programStatusWord[PSW_CARRY_BIT] ==
		($past(a) < $past(b)))
		else $error("reverse difference borrow wrong");

	clamp_kept_a: assert property (
		!psWr |=> $stable(st.programStatusWord[PSW_CLAMP_BIT]))
		else $error("clamp flag changed");

	ext_flags_a: assert property (
		execNow && dExt |=> $stable(st.programStatusWord))
		else $error("widening changed flags");

	trap_entry_a: assert property (
		execNow && dTrap |=> st.savedReturnPc == $past(st.pc) + STEP_LONG
		&& st.programStatusWord[PSW_FAULT_BIT]
		&& st.exceptionCauseReg[7:0] == {3'b010, $past(rs)})
		else $error("exception entry wrong");

	trap_vector_a: assert property (
		execNow && dTrap && rs[4] |=> st.pc == HANDLER_HIGH)
		else $error("upper handler address wrong");

	mem_kind_a: assert property (
		st.mem.req |-> st.mem.half == dSwitch)
		else $error("memory access width wrong");

	mem_hold_a: assert property (
		st.mem.req && !memAck |=> st.mem.req && $stable(st.mem.addr))
		else $error("memory request dropped early");

	probe_null_a: assert property (
		st.phase == ST_WAIT && memAck && !dSwitch |=>
		st.programStatusWord[PSW_NULL_BIT] ==
		!$past(memRdData[st.bitSel]) && st.phase == ST_IDLE)
		else $error("bit probe null flag wrong");

	switch_pc_a: assert property (
		st.phase == ST_WAIT && memAck && dSwitch |=> st.pc[0] == 1'b0
		&& st.pc == $past(st.pc) + STEP_SHORT +
		{{15{$past(memRdData[15])}}, $past(memRdData), 1'b0})
		else $error("table jump target wrong");

	xor_wrap_a: assert property (
		execNow && (dXor || dXori || dTst) |=>
		!st.programStatusWord[PSW_WRAP_BIT] ##1 st.phase == ST_IDLE ||
		st.phase == ST_EXEC)
		else $error("logic op wrap flag not cleared");

endmodule // cpx_exec

/* File: verif/cpx_mem_model.sv */
module cpx_mem_model
	import cpx_pkg::*;
(
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire cpx_mem_req_s memReq,
	input  wire logic [1:0]   lat,
	output logic              memAck,
	output logic [15:0]       memRdData
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [2:0] waitCnt;

	// answers after lat idle cycles; data toggles while idle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			waitCnt   <= 3'h0;
			memAck    <= 1'b0;
			memRdData <= 16'hFFFF;
		end else if (memReq.req && !memAck && waitCnt >= {1'b0, lat}) begin
			memAck    <= 1'b1;
			memRdData <= {memReq.addr[7:0], ~memReq.addr[7:0]};
		end else begin
			memAck    <= 1'b0;
			waitCnt   <= (memReq.req && !memAck) ? waitCnt + 3'h1 : 3'h0;
			memRdData <= ~memRdData;
		end
	end
endmodule // cpx_mem_model

/* File: verif/cpx_exec_tb.sv */
module cpx_exec_tb
	import cpx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct {
		string       nm;
		logic [31:0] v;
		logic        c;
		logic        e;
	} cpx_note_s;

	logic         core_clk = 1'b0;
	logic         rst_n    = 1'b0;
	cpx_apb_req_s apbReq   = '0;
	cpx_apb_rsp_s apbRsp;
	cpx_mem_req_s memReq;
	logic         memAck;
	logic [15:0]  memRdData;
	logic [1:0]   lat      = 2'h0;
	logic [31:0]  rdData, ins, pc, program_status_word, f, a, b, ea, eb, cause = '0;
	logic [31:0]  srv[4];
	logic [4:0]   srn[4]   = '{SR_SAVED_PC, SR_SAVED_PSW, SR_CAUSE, SR_PSW};
	logic [15:0]  d16;
	logic [4:0]   v;
	cpx_note_s    noteQ[$];
	cpx_note_s    curNote;
	int           err_total = 0;
	int           tests_run = 0;

	always #5 core_clk = ~core_clk;

	cpx_exec uut (.core_clk(core_clk), .rst_n(rst_n), .apbReq(apbReq),
		.apbRsp(apbRsp), .memReq(memReq), .memAck(memAck),
		.memRdData(memRdData));
	cpx_mem_model mem (.core_clk(core_clk), .rst_n(rst_n), .memReq(memReq),
		.lat(lat), .memAck(memAck), .memRdData(memRdData));

	// ----------------------------------------------------------------
	// bus tasks and checking
	// ----------------------------------------------------------------
	always @(posedge core_clk) begin
		if (apbReq.psel && apbReq.penable && !apbReq.pwrite &&
			apbRsp.pready === 1'b1 && noteQ.size() > 0) begin
			curNote = noteQ.pop_front();
			if (curNote.c) begin
				tests_run++;
				if (apbRsp.prdata !== curNote.v) begin
					err_total++;
					$display("ERROR %s expected %h seen %h", curNote.nm,
						curNote.v, apbRsp.prdata);
				end
				tests_run++;
				if (apbRsp.pslverr !== curNote.e) begin
					err_total++;
					$display("ERROR %s_err expected %b seen %b",
						curNote.nm, curNote.e, apbRsp.pslverr);
				end
			end
		end
	end

	task automatic apb(logic w, logic [7:0] ad, logic [31:0] d,
		string nm = "", logic c = 1'b0, logic e = 1'b0);
		int n;
		n = 0;
		if (!w) noteQ.push_back('{nm, d, c, e});
		apbReq <= '{1'b1, 1'b0, w, ad, d};
		@(posedge core_clk);
		apbReq.penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (apbRsp.pready !== 1'b1 && n < 50);
		rdData = apbRsp.prdata;
		if (n >= 50) begin
			err_total++;
			$display("ERROR pready expected 1 seen 0");
		end
		apbReq <= '0;
		@(posedge core_clk);
	endtask

	task automatic run(logic [31:0] i, logic [31:0] s = 32'h0);
		int n;
		n = 0;
		apb(1'b1, REG_INSTR, i);
		do begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (rdData[STATUS_BUSY_BIT] !== 1'b0 && n < 20);
		apb(1'b0, REG_STATUS, s, "status", 1'b1);
	endtask

	task automatic setg(logic [4:0] r, logic [31:0] d);
		apb(1'b1, REG_GPR_SEL, {27'h0, r});
		apb(1'b1, REG_GPR_DATA, d);
	endtask

	task automatic chkg(logic [4:0] r, logic [31:0] e, string nm);
		apb(1'b1, REG_GPR_SEL, {27'h0, r});
		apb(1'b0, REG_GPR_DATA, e, nm, 1'b1);
	endtask

	function automatic logic [31:0] fl(logic [31:0] r, logic c, o, sc);
		logic [31:0] p;
		p = program_status_word;
		p[PSW_NULL_BIT] = (r == 32'h0);
		p[PSW_NEG_BIT]  = r[31];
		p[PSW_WRAP_BIT] = o;
		if (sc) p[PSW_CARRY_BIT] = c;
		return p;
	endfunction

	function automatic logic [31:0] sf(logic [31:0] x, y);
		logic [31:0] r;
		r = x - y;
		return fl(r, x < y, (x[31] ^ y[31]) & (r[31] ^ x[31]), 1'b1);
	endfunction

	function automatic logic [31:0] pick();
		case ($urandom_range(0, 4))
			0: return 32'h8000_0000;
			1: return 32'h7FFF_FFFF;
			2: return 32'h0000_8080;
			default: return $urandom;
		endcase
	endfunction

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		#200us;
		err_total++;
		$display("ERROR watchdog expected finish seen hang");
		end_of_test();
	end

	initial begin
		void'($urandom(31));
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		apb(1'b0, REG_PC, RST_PC, "pc", 1'b1);
		apb(1'b0, REG_PSW, RST_PSW, "psw", 1'b1);
		apb(1'b0, 8'h24, 32'h0, "unmapped", 1'b1, 1'b1);
		for (int i = 0; i < 45; i++) begin
			a = pick();
			b = (i < 9) ? a : pick();
			d16 = 16'($urandom);
			program_status_word = {25'h0, 7'($urandom)};
			setg(5'h07, a);
			setg(5'h03, b);
			apb(1'b1, REG_PSW, program_status_word);
			ea = a;
			eb = b;
			f = program_status_word;
			case (i % 9)
				0: ins = {16'h0, 5'h07, OP_SUBTRACT, 5'h03};
				1: ins = {16'h0, 5'h07, OP_REVERSE_DIFF, 5'h03};
				2: ins = {16'h0, 5'h07, OP_AND_FLAGS_ONLY, 5'h03};
				3: ins = {16'h0, 5'h07, OP_EXCL_OR, 5'h03};
				4: ins = {d16, 5'h07, OP_EXCL_OR_LIT, 5'h03};
				5: ins = {16'h0, OPX_SIGN_BYTE, 5'h03};
				6: ins = {16'h0, OPX_SIGN_HALF, 5'h03};
				7: ins = {16'h0, OPX_ZERO_BYTE, 5'h03};
				default: ins = {16'h0, OPX_ZERO_HALF, 5'h03};
			endcase
			case (i % 9)
				0: f = sf(a, b);
				1: f = sf(b, a);
				2: f = fl(a & b, 1'b0, 1'b0, 1'b0);
				3: f = fl(a ^ b, 1'b0, 1'b0, 1'b0);
				4: f = fl(b ^ {16'h0, d16}, 1'b0, 1'b0, 1'b0);
				5: eb = {{24{b[7]}}, b[7:0]};
				6: eb = {{16{b[15]}}, b[15:0]};
				7: eb = {24'h0, b[7:0]};
				8: eb = {16'h0, b[15:0]};
				default: ;
			endcase
			if (i % 9 == 0) ea = a - b;
			if (i % 9 == 1) ea = b - a;
			if (i % 9 == 3) ea = a ^ b;
			if (i % 9 == 4) ea = b ^ {16'h0, d16};
			run(ins);
			chkg(5'h07, ea, "dest");
			chkg(5'h03, eb, "src");
			apb(1'b0, REG_PSW, f, "psw", 1'b1);
		end
		for (int j = 0; j < 2; j++) begin
			v = j ? 5'h10 : 5'h0F;
			pc = $urandom & 32'hFFFF_FFFE;
			program_status_word = {25'h0, 7'($urandom)};
			apb(1'b1, REG_PC, pc);
			apb(1'b1, REG_PSW, program_status_word);
			run({SH_SW_EXCEPTION, OPX_SW_EXCEPTION, v});
			cause = {cause[31:16], EXC_CODE_BASE + {11'h0, v}};
			f = program_status_word;
			f[PSW_FAULT_BIT] = 1'b1;
			f[PSW_IRQ_BLOCK_BIT] = 1'b1;
			srv = '{pc + STEP_LONG, program_status_word, cause, f};
			apb(1'b0, REG_SAVED_PC, srv[0], "savedpc", 1'b1);
			apb(1'b0, REG_SAVED_PSW, program_status_word, "savedpsw", 1'b1);
			apb(1'b0, REG_CAUSE, cause, "cause", 1'b1);
			apb(1'b0, REG_PSW, f, "psw", 1'b1);
			apb(1'b0, REG_PC, j ? HANDLER_HIGH : HANDLER_LOW, "pc", 1'b1);
			// only implemented numbers are read
			for (int k = 0; k < 4; k++) begin
				run({16'h0, 5'h07, OP_EXTENDED, srn[k]});
				chkg(5'h07, srv[k], "sysreg");
			end
			apb(1'b0, REG_SAVED_PC, srv[0], "savedpc", 1'b1);
			apb(1'b0, REG_PSW, f, "psw", 1'b1);
		end
		// unknown opcode: flagged, short step
		apb(1'b1, REG_PC, STEP_LONG);
		run({16'h0, 5'h07, 6'h01, 5'h03}, 32'h1 << STATUS_ILLEGAL_BIT);
		apb(1'b0, REG_PC, STEP_LONG + STEP_SHORT, "pc", 1'b1);
		for (int j = 0; j < 4; j++) begin
			pc = $urandom & 32'h0000_FFFE;
			b = 32'(j * 3 - 4);
			lat <= 2'($urandom);
			apb(1'b1, REG_PC, pc);
			setg(5'h03, b);
			run({16'h0, OPX_TABLE_JUMP, 5'h03});
			a = pc + STEP_SHORT + (b << 1);
			d16 = {a[7:0], ~a[7:0]};
			ea = pc + STEP_SHORT + ({{16{d16[15]}}, d16} << 1);
			apb(1'b0, REG_PC, ea, "pc", 1'b1);
		end
		for (int j = 0; j < 8; j++) begin
			b = $urandom;
			d16 = 16'($urandom);
			program_status_word = {25'h0, 7'($urandom)};
			lat <= 2'($urandom);
			setg(5'h03, b);
			setg(5'h07, ($urandom << 3) | j);
			apb(1'b1, REG_PSW, program_status_word);
			a = b + {{16{d16[15]}}, d16};
			run({d16, 2'h3, 3'(j), OP_BIT_PROBE_DISP, 5'h03});
			program_status_word[PSW_NULL_BIT] = a[j];
			apb(1'b0, REG_PSW, program_status_word, "psw", 1'b1);
			run({SH_BIT_PROBE_REG, 5'h07, OP_EXTENDED, 5'h03});
			program_status_word[PSW_NULL_BIT] = b[j];
			apb(1'b0, REG_PSW, program_status_word, "psw", 1'b1);
		end
		end_of_test();
	end
endmodule // cpx_exec_tb
